// File: hw/offset_host_ctrl.sv
// Local design decisions: the APB register port and the address map.
`include "offset_map.svh"

// How it works
// - x9/x9 offsets use ten to seventeen bits
// - Other bus modes use one bit fewer
// - Bits above the significant width are ignored
// - Deepest x9-in x18-out write takes four cycles
// - Deepest x18-in x9-out read takes four cycles
// - Deepest x9/x9 pass takes six cycles
// - Write strobe loads next offset chunk in order
// - Read strobe presents next offset chunk in order
// - Method chosen only on the first edge after master reset
// - Parallel readback allowed in either method
module offset_host_ctrl
	import offset_pkg::*;
(
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`APB_ADDR_W-1:0] paddr,
	input  wire logic [`APB_DATA_W-1:0] pwdata,
	output logic [`APB_DATA_W-1:0]      prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Link to the device
	offset_link_if.host                 link
);

	typedef struct packed {
		host_state_e       st;
		logic              sel;
		ofs_chunk_t        chunk;
		logic              cap_v;
		logic              cap_sel;
		ofs_chunk_t        cap_chunk;
		ofs_reg_t          ae;
		ofs_reg_t          af;
		logic              done;
		logic              in_wide;
		logic              out_wide;
		logic [`OFS_DEPTH_W-1:0] depth;
		logic [`APB_DATA_W-1:0]  prdata;
		logic              load_n;
		logic              wen_n;
		logic              ren_n;
		ofs_bus_t          din;
	} host_state_s;

	host_state_s s_q;
	host_state_s s_d;
	ofs_sig_t    sig;
	ofs_reg_t    mask;
	ofs_chunk_t  wlast;
	ofs_chunk_t  rlast;
	logic        setup;
	logic        access;
	logic        wr_acc;
	logic        mapped;
	logic        start_wr;
	logic        start_rd;
	logic        pass_end;

	function automatic logic is_mapped(input logic [`APB_ADDR_W-1:0] a);
		is_mapped = (a == `HOST_CTRL_ADDR) || (a == `HOST_AE_ADDR) || (a == `HOST_AF_ADDR)
			|| (a == `HOST_STATUS_ADDR) || (a == `HOST_CONFIG_ADDR);
	endfunction : is_mapped

	always_comb begin
		sig      = sig_bits(s_q.in_wide, s_q.out_wide, s_q.depth);
		mask     = sig_mask(sig);
		wlast    = last_chunk(sig, s_q.in_wide);
		rlast    = last_chunk(sig, s_q.out_wide);
		setup    = psel && !penable;
		access   = psel && penable;
		mapped   = is_mapped(paddr);
		wr_acc   = access && pwrite && mapped;
		start_wr = wr_acc && (paddr == `HOST_CTRL_ADDR) && pwdata[`HOST_CTRL_WRITE_BIT];
		start_rd = wr_acc && (paddr == `HOST_CTRL_ADDR) && pwdata[`HOST_CTRL_READ_BIT]
			&& !pwdata[`HOST_CTRL_WRITE_BIT];
		pass_end = (s_q.sel == `OFS_SEL_FULL) && (s_q.chunk == ((s_q.st == HOST_WRITE)
			? wlast : rlast));
		s_d      = s_q;
		s_d.cap_v = 1'b0;

		// Read data registered in the setup cycle
		if (setup) begin
			case (paddr)
				`HOST_AE_ADDR:     s_d.prdata = {15'h0, s_q.ae};
				`HOST_AF_ADDR:     s_d.prdata = {15'h0, s_q.af};
				`HOST_STATUS_ADDR: s_d.prdata = {30'h0, s_q.done, s_q.st != HOST_IDLE};
				`HOST_CONFIG_ADDR: s_d.prdata = {27'h0, s_q.depth, s_q.out_wide,
					s_q.in_wide};
				default:           s_d.prdata = `APB_WORD_ZERO;
			endcase
		end

		if (wr_acc && s_q.st == HOST_IDLE) begin
			case (paddr)
				`HOST_AE_ADDR: s_d.ae = pwdata[`OFS_REG_W-1:0];
				`HOST_AF_ADDR: s_d.af = pwdata[`OFS_REG_W-1:0];
				`HOST_CONFIG_ADDR: begin
					s_d.in_wide  = pwdata[`HOST_CFG_IN_WIDE_BIT];
					s_d.out_wide = pwdata[`HOST_CFG_OUT_WIDE_BIT];
					s_d.depth    = pwdata[`HOST_CFG_DEPTH_HI:`HOST_CFG_DEPTH_LO];
				end
				default: s_d.depth = s_q.depth;
			endcase
		end
		if (wr_acc && paddr == `HOST_STATUS_ADDR && pwdata[`HOST_STAT_DONE_BIT])
			s_d.done = 1'b0;

		// Readback capture: device word is valid the cycle after its strobe edge
		if (s_q.cap_v) begin
			if (s_q.cap_sel == `OFS_SEL_EMPTY)
				s_d.ae = deposit(s_q.ae, link.dout, s_q.cap_chunk, s_q.out_wide, mask);
			else
				s_d.af = deposit(s_q.af, link.dout, s_q.cap_chunk, s_q.out_wide, mask);
		end

		case (s_q.st)
			HOST_IDLE: begin
				s_d.sel   = `OFS_SEL_EMPTY;
				s_d.chunk = `OFS_CHUNK_FIRST;
				if (start_wr) begin
					s_d.st     = HOST_WRITE;
					s_d.load_n = 1'b0;
					s_d.wen_n  = 1'b0;
					s_d.din    = extract(s_q.ae, `OFS_CHUNK_FIRST, s_q.in_wide);
				end else if (start_rd) begin
					s_d.st     = HOST_READ;
					s_d.load_n = 1'b0;
					s_d.ren_n  = 1'b0;
				end
			end
			HOST_WRITE: begin
				if (pass_end) begin
					s_d.st     = HOST_IDLE;
					s_d.load_n = 1'b1;
					s_d.wen_n  = 1'b1;
					s_d.din    = `OFS_BUS_ZERO;
					s_d.done   = 1'b1;
				end else begin
					if (s_q.chunk == wlast) begin
						s_d.sel   = `OFS_SEL_FULL;
						s_d.chunk = `OFS_CHUNK_FIRST;
					end else begin
						s_d.chunk = s_q.chunk + `OFS_CHUNK_STEP;
					end
					s_d.din = extract((s_d.sel == `OFS_SEL_EMPTY) ? s_q.ae : s_q.af,
						s_d.chunk, s_q.in_wide);
				end
			end
			HOST_READ: begin
				s_d.cap_v     = 1'b1;
				s_d.cap_sel   = s_q.sel;
				s_d.cap_chunk = s_q.chunk;
				if (pass_end) begin
					s_d.st     = HOST_DRAIN;
					s_d.load_n = 1'b1;
					s_d.ren_n  = 1'b1;
				end else if (s_q.chunk == rlast) begin
					s_d.sel   = `OFS_SEL_FULL;
					s_d.chunk = `OFS_CHUNK_FIRST;
				end else begin
					s_d.chunk = s_q.chunk + `OFS_CHUNK_STEP;
				end
			end
			HOST_DRAIN: begin
				s_d.st   = HOST_IDLE;
				s_d.done = 1'b1;
			end
			default: begin
				s_d.st     = HOST_IDLE;
				s_d.load_n = 1'b1;
				s_d.wen_n  = 1'b1;
				s_d.ren_n  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q        <= '0;
			s_q.st     <= HOST_IDLE;
			s_q.load_n <= 1'b1;
			s_q.wen_n  <= 1'b1;
			s_q.ren_n  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.prdata;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	assign link.load_select_n         = s_q.load_n;
	assign link.write_en_n            = s_q.wen_n;
	assign link.read_en_n             = s_q.ren_n;
	// Parallel method only; the method strap is held at the device and not changed here
	assign link.serial_shift_enable_n = 1'b1;
	assign link.din                   = s_q.din;

endmodule : offset_host_ctrl

// File: hw/offset_map.svh
`ifndef OFFSET_MAP_SVH
`define OFFSET_MAP_SVH

// Link and register widths
`define OFS_BUS_W            18
`define OFS_REG_W            17
`define OFS_DEPTH_W          3
`define OFS_SIG_W            5
`define OFS_SIG_BASE_X9X9    5'd10
`define OFS_SIG_BASE_OTHER   5'd9
`define OFS_NARROW_BITS      5'd8
`define OFS_WIDE_BITS        5'd16
`define OFS_NARROW_CMASK     17'h000ff
`define OFS_WIDE_CMASK       17'h0ffff
`define OFS_ONE              17'h00001
`define OFS_REG_ZERO         17'h00000
`define OFS_BUS_ZERO         18'h00000

// Register select inside a pass
`define OFS_SEL_EMPTY        1'b0
`define OFS_SEL_FULL         1'b1
`define OFS_CHUNK_FIRST      2'd0
`define OFS_CHUNK_STEP       2'd1

// Host controller APB map
`define APB_ADDR_W           12
`define APB_DATA_W           32
`define HOST_CTRL_ADDR       12'h000
`define HOST_AE_ADDR         12'h004
`define HOST_AF_ADDR         12'h008
`define HOST_STATUS_ADDR     12'h00c
`define HOST_CONFIG_ADDR     12'h010
`define HOST_CTRL_WRITE_BIT  0
`define HOST_CTRL_READ_BIT   1
`define HOST_STAT_BUSY_BIT   0
`define HOST_STAT_DONE_BIT   1
`define HOST_CFG_IN_WIDE_BIT 0
`define HOST_CFG_OUT_WIDE_BIT 1
`define HOST_CFG_DEPTH_LO    2
`define HOST_CFG_DEPTH_HI    4
`define HOST_CONFIG_RESET    3'h0
`define APB_WORD_ZERO        32'h00000000

`endif

// File: hw/offset_pkg.sv
`include "offset_map.svh"

package offset_pkg;

	typedef logic [`OFS_REG_W-1:0] ofs_reg_t;
	typedef logic [`OFS_BUS_W-1:0] ofs_bus_t;
	typedef logic [1:0]            ofs_chunk_t;
	typedef logic [`OFS_SIG_W-1:0] ofs_sig_t;

	typedef enum logic [3:0] {
		HOST_IDLE  = 4'b0001,
		HOST_WRITE = 4'b0010,
		HOST_READ  = 4'b0100,
		HOST_DRAIN = 4'b1000
	} host_state_e;

	// Significant offset bits for a bus configuration and depth
	function automatic ofs_sig_t sig_bits(input logic in_wide, input logic out_wide,
		input logic [`OFS_DEPTH_W-1:0] depth);
		ofs_sig_t base;
		base = (!in_wide && !out_wide) ? `OFS_SIG_BASE_X9X9 : `OFS_SIG_BASE_OTHER;
		sig_bits = base + ofs_sig_t'(depth);
	endfunction : sig_bits

	function automatic ofs_reg_t sig_mask(input ofs_sig_t sig);
		sig_mask = (`OFS_ONE << sig) - `OFS_ONE;
	endfunction : sig_mask

	// Index of the last chunk of one register on a port of the given width
	function automatic ofs_chunk_t last_chunk(input ofs_sig_t sig, input logic wide);
		if (wide)
			last_chunk = (sig > `OFS_WIDE_BITS) ? 2'd1 : 2'd0;
		else if (sig > `OFS_WIDE_BITS)
			last_chunk = 2'd2;
		else if (sig > `OFS_NARROW_BITS)
			last_chunk = 2'd1;
		else
			last_chunk = 2'd0;
	endfunction : last_chunk

	function automatic logic [4:0] chunk_shift(input ofs_chunk_t k, input logic wide);
		chunk_shift = wide ? {k[0], 4'h0} : {k, 3'h0};
	endfunction : chunk_shift

	// Places one bus word into its chunk of a register; bits above sig are dropped
	function automatic ofs_reg_t deposit(input ofs_reg_t old, input ofs_bus_t data,
		input ofs_chunk_t k, input logic wide, input ofs_reg_t mask);
		ofs_reg_t cmask;
		ofs_reg_t fmask;
		cmask = wide ? `OFS_WIDE_CMASK : `OFS_NARROW_CMASK;
		fmask = cmask << chunk_shift(k, wide);
		deposit = ((old & ~fmask) | ((data[`OFS_REG_W-1:0] & cmask) << chunk_shift(k, wide)))
			& mask;
	endfunction : deposit

	function automatic ofs_bus_t extract(input ofs_reg_t val, input ofs_chunk_t k,
		input logic wide);
		ofs_reg_t cmask;
		cmask = wide ? `OFS_WIDE_CMASK : `OFS_NARROW_CMASK;
		extract = {1'b0, (val >> chunk_shift(k, wide)) & cmask};
	endfunction : extract

endpackage : offset_pkg

// File: hw/offset_link_if.sv
interface offset_link_if;
	import offset_pkg::*;

	logic     load_select_n;
	logic     write_en_n;
	logic     read_en_n;
	logic     serial_shift_enable_n;
	ofs_bus_t din;
	ofs_bus_t dout;

	modport dev (
		input  load_select_n,
		input  write_en_n,
		input  read_en_n,
		input  serial_shift_enable_n,
		input  din,
		output dout
	);

	modport host (
		output load_select_n,
		output write_en_n,
		output read_en_n,
		output serial_shift_enable_n,
		output din,
		input  dout
	);
endinterface : offset_link_if

// File: hw/offset_regs_dev.sv
`include "offset_map.svh"

module offset_regs_dev
	import offset_pkg::*;
(
	// Clock and master reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// Link to the host
	offset_link_if.dev                  link,
	// Configuration straps
	input  wire logic                   in_wide,
	input  wire logic                   out_wide,
	input  wire logic [`OFS_DEPTH_W-1:0] depth_sel,
	input  wire logic                   serial_method,
	// Offset values and programming method flag to the flag logic
	output ofs_reg_t                    almost_empty_offset,
	output ofs_reg_t                    almost_full_offset,
	output logic                        serial_mode
);

	typedef struct packed {
		ofs_reg_t   ae;
		ofs_reg_t   af;
		logic       wsel;
		ofs_chunk_t wchunk;
		logic       rsel;
		ofs_chunk_t rchunk;
		ofs_bus_t   dout;
		logic       serial;
		logic       strapped;
	} dev_state_s;

	dev_state_s s_q;
	dev_state_s s_d;
	ofs_sig_t   sig;
	ofs_reg_t   mask;
	ofs_chunk_t wlast;
	ofs_chunk_t rlast;
	logic       wr_hit;
	logic       rd_hit;

	always_comb begin
		sig    = sig_bits(in_wide, out_wide, depth_sel);
		mask   = sig_mask(sig);
		wlast  = last_chunk(sig, in_wide);
		rlast  = last_chunk(sig, out_wide);
		wr_hit = !link.load_select_n && !link.write_en_n && link.read_en_n
			&& link.serial_shift_enable_n && !s_q.serial;
		rd_hit = !link.load_select_n && link.write_en_n && !link.read_en_n
			&& link.serial_shift_enable_n;
		s_d = s_q;
		// Programming method is caught once, on the first edge after master reset
		if (!s_q.strapped) begin
			s_d.serial   = serial_method;
			s_d.strapped = 1'b1;
		end
		if (wr_hit && s_q.strapped) begin
			if (s_q.wsel == `OFS_SEL_EMPTY)
				s_d.ae = deposit(s_q.ae, link.din, s_q.wchunk, in_wide, mask);
			else
				s_d.af = deposit(s_q.af, link.din, s_q.wchunk, in_wide, mask);
			if (s_q.wchunk == wlast) begin
				s_d.wchunk = `OFS_CHUNK_FIRST;
				s_d.wsel   = !s_q.wsel;
			end else begin
				s_d.wchunk = s_q.wchunk + `OFS_CHUNK_STEP;
			end
		end
		if (rd_hit) begin
			s_d.dout = extract((s_q.rsel == `OFS_SEL_EMPTY) ? s_q.ae : s_q.af,
				s_q.rchunk, out_wide);
			if (s_q.rchunk == rlast) begin
				s_d.rchunk = `OFS_CHUNK_FIRST;
				s_d.rsel   = !s_q.rsel;
			end else begin
				s_d.rchunk = s_q.rchunk + `OFS_CHUNK_STEP;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.dout           = s_q.dout;
	assign almost_empty_offset = s_q.ae;
	assign almost_full_offset  = s_q.af;
	assign serial_mode         = s_q.serial;

endmodule : offset_regs_dev

// File: verification/flag_offset_parallel_access_assertions.sv
module flag_offset_parallel_access_assertions
	import offset_pkg::*;
(
	// Clock and master reset
	input wire logic     pclk,
	input wire logic     presetn,
	// Link signals
	input wire logic     load_select_n,
	input wire logic     write_en_n,
	input wire logic     read_en_n,
	input wire logic     serial_shift_enable_n,
	input wire ofs_bus_t din,
	input wire ofs_bus_t dout
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       wr;
	logic       rd;
	logic [2:0] wr_q;
	logic [2:0] rd_q;

	assign wr = !load_select_n && !write_en_n && read_en_n;
	assign rd = !load_select_n && write_en_n && !read_en_n;

	// Length of the current run of strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= 3'h0;
			rd_q <= 3'h0;
		end else begin
			wr_q <= wr ? wr_q + 3'h1 : 3'h0;
			rd_q <= rd ? rd_q + 3'h1 : 3'h0;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_SEN_HIGH: assert property (serial_shift_enable_n)
		else $error("serial enable driven low");
	AST_ONE_STROBE: assert property (write_en_n || read_en_n)
		else $error("write and read strobes together");
	AST_STROBE_LOAD: assert property (!write_en_n || !read_en_n |-> !load_select_n)
		else $error("strobe without load select");
	AST_DIN_TOP: assert property (din[17] == 1'b0)
		else $error("input word top bit set");
	AST_DOUT_TOP: assert property (dout[17] == 1'b0)
		else $error("output word top bit set");
	AST_DOUT_HOLD: assert property (!rd |=> $stable(dout))
		else $error("output word moved without read strobe");
	AST_WR_RUN: assert property (wr_q <= 3'd6)
		else $error("write pass too long");
	AST_RD_RUN: assert property (rd_q <= 3'd6)
		else $error("read pass too long");
	AST_WR_MIN: assert property ($rose(write_en_n) |-> $past(write_en_n, 2) == 1'b0)
		else $error("write pass shorter than two cycles");
endmodule : flag_offset_parallel_access_assertions

// File: verification/flag_offset_parallel_access_bench.sv
module flag_offset_parallel_access_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import offset_pkg::*;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        iw = 1'b0;
	logic        ow = 1'b0;
	logic [2:0]  dsel = 3'h0;
	logic        smeth = 1'b0;
	ofs_reg_t    ae_o;
	ofs_reg_t    af_o;
	logic        smode;
	int          fails = 0;
	int          num_checks = 0;
	int          wr_n = 0;
	int          rd_n = 0;

	offset_link_if link();
	offset_regs_dev i_offset_regs_dev (.pclk(pclk), .presetn(presetn), .link(link),
		.in_wide(iw), .out_wide(ow), .depth_sel(dsel), .serial_method(smeth),
		.almost_empty_offset(ae_o), .almost_full_offset(af_o), .serial_mode(smode));
	offset_host_ctrl i_offset_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	flag_offset_parallel_access_assertions chk (.pclk(pclk), .presetn(presetn),
		.load_select_n(link.load_select_n), .write_en_n(link.write_en_n),
		.read_en_n(link.read_en_n), .serial_shift_enable_n(link.serial_shift_enable_n),
		.din(link.din), .dout(link.dout));

	always #2 pclk = ~pclk;

	// Strobes the device samples at each edge
	always @(posedge pclk) begin
		if (!link.load_select_n && !link.write_en_n && link.read_en_n)
			wr_n++;
		if (!link.load_select_n && link.write_en_n && !link.read_en_n)
			rd_n++;
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task cmp(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	task apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20) begin
			fails++;
			end_of_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rst(logic i, logic o, logic [2:0] d, logic s);
		presetn <= 1'b0;
		iw <= i;
		ow <= o;
		dsel <= d;
		smeth <= s;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst

	// Start a pass, poll done, then clear it
	task run(logic [31:0] c);
		logic [31:0] r;
		logic        e;
		int          n;
		apb(1'b1, 12'h000, c, r, e);
		for (n = 0; n < 40; n++) begin
			apb(1'b0, 12'h00c, 32'h0, r, e);
			if (n == 0)
				cmp("busy", 32'h1, {31'h0, r[0]});
			if (r[1] === 1'b1)
				break;
		end
		if (n == 40) begin
			fails++;
			end_of_test();
		end
		apb(1'b1, 12'h00c, 32'h2, r, e);
	endtask : run

	task t_regs;
		logic [31:0] r;
		logic        e;
		rst(1'b0, 1'b0, 3'h0, 1'b0);
		apb(1'b0, 12'h004, 32'h0, r, e);
		cmp("ae reset", 32'h0, r);
		apb(1'b0, 12'h00c, 32'h0, r, e);
		cmp("status reset", 32'h0, r);
		apb(1'b1, 12'h010, 32'h1f, r, e);
		apb(1'b0, 12'h010, 32'h0, r, e);
		cmp("config", 32'h1f, r);
		apb(1'b0, 12'h014, 32'h0, r, e);
		cmp("unmapped err", 32'h1, {31'h0, e});
		$display("test regs done");
	endtask : t_regs

	task t_pass(logic i, logic o, logic [2:0] d);
		logic [31:0] r;
		logic [31:0] m;
		logic [31:0] ae;
		logic [31:0] af;
		logic        e;
		int          s;
		s = ((i || o) ? 9 : 10) + d;
		m = (32'h1 << s) - 32'h1;
		rst(i, o, d, 1'b0);
		apb(1'b1, 12'h010, {27'h0, d, o, i}, r, e);
		for (int k = 0; k < 2; k++) begin
			ae = k ? 32'h0fedc : 32'h1a5c3;
			af = k ? 32'h12345 : 32'h1ffff;
			apb(1'b1, 12'h004, ae, r, e);
			apb(1'b1, 12'h008, af, r, e);
			wr_n = 0;
			run(32'h1);
			cmp("write cycles", 2 * ((s + (i ? 15 : 7)) / (i ? 16 : 8)), wr_n);
			cmp("dev empty", ae & m, {15'h0, ae_o});
			cmp("dev full", af & m, {15'h0, af_o});
			cmp("parallel mode", 32'h0, {31'h0, smode});
			apb(1'b1, 12'h004, 32'h0, r, e);
			apb(1'b1, 12'h008, 32'h0, r, e);
			rd_n = 0;
			run(32'h2);
			cmp("read cycles", 2 * ((s + (o ? 15 : 7)) / (o ? 16 : 8)), rd_n);
			apb(1'b0, 12'h004, 32'h0, r, e);
			cmp("read empty", ae & m, r);
			apb(1'b0, 12'h008, 32'h0, r, e);
			cmp("read full", af & m, r);
		end
		$display("test pass %0d %0d %0d done", i, o, d);
	endtask : t_pass

	task t_serial;
		logic [31:0] r;
		logic        e;
		rst(1'b0, 1'b0, 3'h7, 1'b1);
		apb(1'b1, 12'h010, 32'h1c, r, e);
		apb(1'b1, 12'h004, 32'h155, r, e);
		run(32'h1);
		cmp("serial mode", 32'h1, {31'h0, smode});
		cmp("serial no write", 32'h0, {15'h0, ae_o});
		rd_n = 0;
		run(32'h2);
		cmp("serial read cycles", 32'd6, rd_n);
		apb(1'b0, 12'h004, 32'h0, r, e);
		cmp("serial readback", 32'h0, r);
		$display("test serial done");
	endtask : t_serial

	initial begin
		t_regs();
		t_pass(1'b0, 1'b0, 3'h7);
		t_pass(1'b0, 1'b1, 3'h7);
		t_pass(1'b1, 1'b0, 3'h7);
		t_pass(1'b0, 1'b0, 3'h0);
		t_pass(1'b1, 1'b1, 3'h3);
		t_serial();
		end_of_test();
	end
endmodule : flag_offset_parallel_access_bench
